// ### hw/irt_pkg.sv
// Constants, types and shared helpers of the remote-control timer and carrier block
package irt_pkg;

  localparam int CLOCK_PERIOD_NS = 10;
  localparam int REG_W = 10;
  localparam int COUNT_W = 9;
  localparam int PART_W = 5;
  localparam int PART_B_LSB = 5;
  localparam int ENABLE_BIT = 9;
  localparam int CARRIER_DISABLE_BIT = 9;
  localparam int LOW_FIXED_BIT = 9;

  // Timing in system clock periods; CARRIER_STEP is in doubled-clock steps per clock
  localparam int PRESCALE_CYCLES = 64;
  localparam int END_SHORTEN_CYCLES = 4;
  localparam int CARRIER_STEP = 2;

  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_LAST = 7'h7F;
  localparam logic [PRE_W-1:0] PRE_RELOAD = PRE_LAST - PRE_W'(PRESCALE_CYCLES - 1);
  // First decrement arrives 2*64-4 clocks after the load
  localparam logic [PRE_W-1:0] PRE_START =
    PRE_LAST - PRE_W'(2 * PRESCALE_CYCLES - END_SHORTEN_CYCLES - 1);

  localparam logic [COUNT_W-1:0] COUNT_RST = 9'h000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 9'h1FF;
  localparam logic [COUNT_W-1:0] MOD_RST = 9'h001;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic DISABLE_RST = 1'b0;

  typedef enum logic [3:0] {
    SEL_TIMER_FULL = 4'h0,
    SEL_TIMER_A    = 4'h1,
    SEL_TIMER_B    = 4'h2,
    SEL_LOW_FULL   = 4'h3,
    SEL_LOW_A      = 4'h4,
    SEL_LOW_B      = 4'h5,
    SEL_HIGH_FULL  = 4'h6,
    SEL_HIGH_A     = 4'h7,
    SEL_HIGH_B     = 4'h8
  } irt_sel_t;

  typedef enum logic [2:0] {
    CAR_IDLE = 3'b001,
    CAR_LOW  = 3'b010,
    CAR_HIGH = 3'b100
  } irt_car_state_t;

  // Merge a write into a 10-bit register: full value, part a (bits 4:0) or part b (9:5)
  function automatic logic [REG_W-1:0] irt_merge(input logic [REG_W-1:0] old_value,
                                                 input logic [REG_W-1:0] data,
                                                 input logic [1:0]       which);
    logic [REG_W-1:0] result;
    result = old_value;
    case (which)
      2'd0: result = data;
      2'd1: result[PART_W-1:0] = data[PART_W-1:0];
      default: result[REG_W-1:PART_B_LSB] = data[PART_W-1:0];
    endcase
    return result;
  endfunction

  // Field read: full value, part a or part b in the low bits
  function automatic logic [REG_W-1:0] irt_field(input logic [REG_W-1:0] value,
                                                 input logic [1:0]       which);
    logic [REG_W-1:0] result;
    result = value;
    if (which == 2'd1) begin
      result = {5'h00, value[PART_W-1:0]};
    end else if (which == 2'd2) begin
      result = {5'h00, value[REG_W-1:PART_B_LSB]};
    end
    return result;
  endfunction

endpackage

// ### hw/irt_carrier_if.sv
// Link between the timer core and its carrier generator
`timescale 1ns/100ps
`default_nettype none
interface irt_carrier_if;
  import irt_pkg::*;
  logic                start;
  logic                run;
  logic [COUNT_W-1:0]  high_mod;
  logic [COUNT_W-1:0]  low_mod;
  logic                level;
  logic                active;

  modport timer (output start, output run, output high_mod, output low_mod,
                 input level, input active);
  modport carrier (input start, input run, input high_mod, input low_mod,
                   output level, output active);
endinterface
`default_nettype wire

// ### hw/irt_prescaler.sv
// Divide-by-64 prescaler that paces the down counter
`timescale 1ns/100ps
`default_nettype none
module irt_prescaler (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clear,
  input  wire logic load_first,
  input  wire logic load_chain,
  input  wire logic run,
  output var  logic tick
);
  import irt_pkg::*;

  logic [PRE_W-1:0] pre;

  assign tick = run && (pre == PRE_LAST);

  always_ff @(posedge clock) begin
    if (reset || clear) begin
      pre <= PRE_START;
    end else if (load_first) begin
      pre <= PRE_START;
    end else if (load_chain) begin
      pre <= PRE_RELOAD;
    end else if (tick) begin
      pre <= PRE_RELOAD;
    end else if (run) begin
      pre <= pre + 7'h01;
    end
  end

  chk_prescale_reload: assert property (@(posedge clock) disable iff (reset)
    (tick && !clear && !load_first && !load_chain) |=> pre == PRE_RELOAD)
    else $error("prescaler did not reload after a tick");

  chk_first_gap: assert property (@(posedge clock) disable iff (reset)
    (load_first && !clear) |=> pre == PRE_START)
    else $error("first prescaler interval not set on load");

endmodule
`default_nettype wire

// ### hw/irt_carrier.sv
// Carrier generator: half-period counter with separate high and low modulo lengths
`timescale 1ns/100ps
`default_nettype none
module irt_carrier (
  input  wire logic   clock,
  input  wire logic   reset,
  irt_carrier_if.carrier link
);
  import irt_pkg::*;

  irt_car_state_t   state;
  logic [COUNT_W-1:0] acc;
  logic [REG_W-1:0]   phase_len;
  logic [REG_W-1:0]   sum;
  logic               wrap;

  // Two doubled-clock steps per system clock; the leftover carries into the next phase
  always_comb begin
    phase_len = (state == CAR_HIGH) ? {1'b0, link.high_mod} + 10'h001
                                    : {1'b0, link.low_mod} + 10'h001;
    sum = {1'b0, acc} + REG_W'(CARRIER_STEP);
    wrap = (sum >= phase_len);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= CAR_IDLE;
    end else if (link.start) begin
      state <= CAR_LOW;
    end else begin
      unique case (state)
        CAR_IDLE: state <= CAR_IDLE;
        CAR_LOW: begin
          if (!link.run) begin
            state <= CAR_IDLE;
          end else if (wrap) begin
            state <= CAR_HIGH;
          end
        end
        CAR_HIGH: begin
          if (wrap) begin
            state <= link.run ? CAR_LOW : CAR_IDLE;
          end
        end
        default: state <= CAR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset || link.start || state == CAR_IDLE) begin
      acc <= COUNT_RST;
    end else if (wrap) begin
      acc <= COUNT_W'(sum - phase_len);
    end else begin
      acc <= sum[COUNT_W-1:0];
    end
  end

  assign link.level = (state == CAR_HIGH);
  assign link.active = (state != CAR_IDLE);

  chk_start_low: assert property (@(posedge clock) disable iff (reset)
    link.start |=> state == CAR_LOW)
    else $error("carrier did not start in its low phase");

  chk_high_finish: assert property (@(posedge clock) disable iff (reset)
    (state == CAR_HIGH && !wrap && !link.start) |=> state == CAR_HIGH)
    else $error("high phase cut short");

  cov_high_to_idle: cover property (@(posedge clock) disable iff (reset)
    state == CAR_HIGH ##1 state == CAR_IDLE);

endmodule
`default_nettype wire

// ### hw/irt_timer.sv
// Remote-control transmission timer: down counter, pin drive, halt release, carrier
`timescale 1ns/100ps
`default_nettype none
module irt_timer (
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic                   wr_en,
  input  wire irt_pkg::irt_sel_t      wr_sel,
  input  wire logic [irt_pkg::REG_W-1:0] wr_data,
  input  wire irt_pkg::irt_sel_t      rd_sel,
  output var  logic [irt_pkg::REG_W-1:0] rd_data,
  input  wire logic                   stop_mode,
  input  wire logic                   halt_wait,
  output var  logic                   timer_end,
  output var  logic                   halt_release,
  output var  logic                   ir_drive_pin,
  output var  logic                   indicator_pin
);
  import irt_pkg::*;

  logic [COUNT_W-1:0] countdown_bits;
  logic               timer_out_enable;
  logic [COUNT_W-1:0] low_phase_modulo;
  logic [COUNT_W-1:0] high_phase_modulo;
  logic               carrier_disable;

  logic [COUNT_W-1:0] next_count;
  logic               next_enable;
  logic [REG_W-1:0]   next_timer;
  logic [REG_W-1:0]   next_low;
  logic [REG_W-1:0]   next_high;
  logic               timer_load;
  logic               low_load;
  logic               high_load;
  logic               start;
  logic               chain;
  logic               tick;
  logic               running;
  logic [1:0]         wr_part;

  irt_carrier_if car ();

  assign running = (countdown_bits != COUNT_RST);

  // Which part of a register a write or read touches
  function automatic logic [1:0] part_of(input irt_sel_t sel);
    logic [1:0] which;
    which = 2'd0;
    if (sel == SEL_TIMER_A || sel == SEL_LOW_A || sel == SEL_HIGH_A) begin
      which = 2'd1;
    end else if (sel == SEL_TIMER_B || sel == SEL_LOW_B || sel == SEL_HIGH_B) begin
      which = 2'd2;
    end
    return which;
  endfunction

  always_comb begin
    wr_part = part_of(wr_sel);
    timer_load = wr_en && !stop_mode &&
                 (wr_sel == SEL_TIMER_FULL || wr_sel == SEL_TIMER_A || wr_sel == SEL_TIMER_B);
    low_load = wr_en && (wr_sel == SEL_LOW_FULL || wr_sel == SEL_LOW_A || wr_sel == SEL_LOW_B);
    high_load = wr_en &&
                (wr_sel == SEL_HIGH_FULL || wr_sel == SEL_HIGH_A || wr_sel == SEL_HIGH_B);
    next_timer = irt_merge({timer_out_enable, countdown_bits}, wr_data, wr_part);
    next_low = irt_merge({1'b0, low_phase_modulo}, wr_data, wr_part);
    next_high = irt_merge({carrier_disable, high_phase_modulo}, wr_data, wr_part);
    start = timer_load && (next_timer[COUNT_W-1:0] != COUNT_RST);
    // A load onto a still-running count reloads a full 64-clock prescaler interval, so the 4-clock loss
    // of the first interval is paid only once
    chain = start && running;
  end

  always_comb begin
    next_enable = timer_load ? next_timer[ENABLE_BIT] : timer_out_enable;
    if (stop_mode) begin
      next_count = COUNT_RST;
    end else if (timer_load) begin
      if (!chain) begin
        next_count = next_timer[COUNT_W-1:0];
      end else if (next_timer[COUNT_W-1:0] == COUNT_MAX) begin
        next_count = COUNT_MAX;
      end else begin
        next_count = next_timer[COUNT_W-1:0] + 9'h001;
      end
    end else if (tick) begin
      next_count = countdown_bits - 9'h001;
    end else begin
      next_count = countdown_bits;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      countdown_bits <= COUNT_RST;
      timer_out_enable <= ENABLE_RST;
    end else begin
      countdown_bits <= next_count;
      timer_out_enable <= next_enable;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      low_phase_modulo <= MOD_RST;
      high_phase_modulo <= MOD_RST;
      carrier_disable <= DISABLE_RST;
    end else begin
      if (low_load) begin
        low_phase_modulo <= next_low[COUNT_W-1:0];
      end
      if (high_load) begin
        high_phase_modulo <= next_high[COUNT_W-1:0];
        carrier_disable <= next_high[CARRIER_DISABLE_BIT];
      end
    end
  end

  // Reads return a field in the low bits; the low modulo's bit 9 always reads zero
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_data <= '0;
    end else begin
      unique case (rd_sel)
        SEL_TIMER_FULL, SEL_TIMER_A, SEL_TIMER_B:
          rd_data <= irt_field({timer_out_enable, countdown_bits}, part_of(rd_sel));
        SEL_LOW_FULL, SEL_LOW_A, SEL_LOW_B:
          rd_data <= irt_field({1'b0, low_phase_modulo}, part_of(rd_sel));
        SEL_HIGH_FULL, SEL_HIGH_A, SEL_HIGH_B:
          rd_data <= irt_field({carrier_disable, high_phase_modulo}, part_of(rd_sel));
        default: rd_data <= '0;
      endcase
    end
  end

  irt_prescaler u_prescaler (
    .clock      (clock),
    .reset      (reset),
    .clear      (stop_mode),
    .load_first (start && !chain),
    .load_chain (chain),
    .run        (running && !stop_mode),
    .tick       (tick)
  );

  assign car.start = start && next_enable && !carrier_disable;
  assign car.run = running && timer_out_enable && !carrier_disable && !stop_mode;
  assign car.high_mod = high_phase_modulo;
  assign car.low_mod = low_phase_modulo;

  irt_carrier u_carrier (
    .clock (clock),
    .reset (reset),
    .link  (car)
  );

  // End and indicator pins follow the count of the same cycle; IR lags its source (count or carrier) by one clock
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_end <= 1'b1;
      indicator_pin <= 1'b1;
      ir_drive_pin <= 1'b0;
    end else begin
      timer_end <= (next_count == COUNT_RST);
      indicator_pin <= !(next_enable && next_count != COUNT_RST);
      ir_drive_pin <= timer_out_enable &&
                      ((running && carrier_disable) || car.level);
    end
  end

  // Timer-wait halt: one release pulse per wait, then the core drops halt_wait
  always_ff @(posedge clock) begin
    if (reset) begin
      halt_release <= 1'b0;
    end else begin
      halt_release <= halt_wait && !running && !halt_release;
    end
  end

  chk_zero_stays: assert property (@(posedge clock) disable iff (reset)
    (!running && !timer_load) |=> !running)
    else $error("stopped timer restarted without a load");

  chk_zero_load_idle: assert property (@(posedge clock) disable iff (reset)
    (timer_load && wr_data[COUNT_W-1:0] == COUNT_RST && wr_sel == SEL_TIMER_FULL)
    |=> !running)
    else $error("zero load started the timer");

  chk_step_one: assert property (@(posedge clock) disable iff (reset)
    (running && !timer_load && !stop_mode) |=>
    (countdown_bits == $past(countdown_bits) || countdown_bits == $past(countdown_bits) - 9'h001))
    else $error("counter moved by more than one");

  chk_tick_spacing: assert property (@(posedge clock) disable iff (reset)
    (tick && !timer_load && !stop_mode) |=> !tick [*8])
    else $error("decrements too close together");

  chk_end_level: assert property (@(posedge clock) disable iff (reset)
    !running |-> timer_end)
    else $error("end signal missing while stopped");

  chk_indicator_run: assert property (@(posedge clock) disable iff (reset)
    (timer_out_enable && running) |-> !indicator_pin)
    else $error("indicator not low while running");

  chk_ir_disabled: assert property (@(posedge clock) disable iff (reset)
    !timer_out_enable |=> !ir_drive_pin)
    else $error("IR pin driven with output enable clear");

  chk_ir_steady: assert property (@(posedge clock) disable iff (reset)
    (timer_out_enable && running && carrier_disable) |=> ir_drive_pin)
    else $error("IR pin not steady high with carrier disabled");

  chk_halt_release: assert property (@(posedge clock) disable iff (reset)
    (halt_wait && !running && !halt_release) |=> halt_release)
    else $error("halt not released at timer end");

  chk_stop_clears: assert property (@(posedge clock) disable iff (reset)
    stop_mode |=> !running)
    else $error("stop standby left a count");

  chk_low_bit_zero: assert property (@(posedge clock) disable iff (reset)
    rd_sel == SEL_LOW_FULL |=> !rd_data[LOW_FIXED_BIT])
    else $error("low modulo bit 9 read as one");

  cov_start: cover property (@(posedge clock) disable iff (reset) start && !chain);
  cov_chain: cover property (@(posedge clock) disable iff (reset) chain);
  cov_release: cover property (@(posedge clock) disable iff (reset) halt_release);
  cov_carrier_end: cover property (@(posedge clock) disable iff (reset)
    car.level && !running);

endmodule
`default_nettype wire

// ### test/irt_led_model.sv
// IR emitter and indicator lamp load, timing each lit run of both and each dark run of the emitter
`timescale 1ns/100ps
`default_nettype none
module irt_led_model (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic ir_drive_pin,
  input  wire logic indicator_pin,
  output var  int   ind_low_len,
  output var  int   ir_high_len,
  output var  int   ir_low_len,
  output var  int   ir_rises
);
  int   ind_run;
  int   ir_run;
  logic ir_last;

  // Lamp is active low: a lit run closes on the first high sample
  always_ff @(posedge clock) begin
    if (reset) begin
      ind_run     <= 0;
      ind_low_len <= 0;
    end else if (!indicator_pin) begin
      ind_run <= ind_run + 1;
    end else if (ind_run != 0) begin
      ind_low_len <= ind_run;
      ind_run     <= 0;
    end
  end

  // A run still open when the emitter goes quiet is never reported
  always_ff @(posedge clock) begin
    if (reset) begin
      ir_run      <= 0;
      ir_last     <= 1'b0;
      ir_high_len <= 0;
      ir_low_len  <= 0;
      ir_rises    <= 0;
    end else if (ir_drive_pin == ir_last) begin
      ir_run <= ir_run + 1;
    end else begin
      if (ir_last) begin
        ir_high_len <= ir_run;
      end else begin
        ir_low_len <= ir_run;
        ir_rises   <= ir_rises + 1;
      end
      ir_run  <= 1;
      ir_last <= ir_drive_pin;
    end
  end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the remote-control timer driving its LED load
`timescale 1ns/100ps
`default_nettype none
module tb;
  import irt_pkg::*;
  logic             clock;
  logic             reset;
  logic             wr_en;
  logic             stop_mode;
  logic             halt_wait;
  irt_sel_t         wr_sel;
  irt_sel_t         rd_sel;
  logic [REG_W-1:0] wr_data;
  logic [REG_W-1:0] rd_data;
  logic             timer_end;
  logic             halt_release;
  logic             ir_drive_pin;
  logic             indicator_pin;
  int               ind_low_len;
  int               ir_high_len;
  int               ir_low_len;
  int               ir_rises;
  int               n_fail;
  int               check_count;
  int               seed;
  int               n1;
  int               n2;
  int               k_hi;
  int               k_lo;
  int               d;
  int               j;
  int               rel_early;
  int               mdl[2];

  irt_timer irt_timer_i (.clock(clock), .reset(reset), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .rd_sel(rd_sel), .rd_data(rd_data), .stop_mode(stop_mode),
    .halt_wait(halt_wait), .timer_end(timer_end), .halt_release(halt_release),
    .ir_drive_pin(ir_drive_pin), .indicator_pin(indicator_pin));

  irt_led_model irt_led_model_i (.clock(clock), .reset(reset), .ir_drive_pin(ir_drive_pin),
    .indicator_pin(indicator_pin), .ind_low_len(ind_low_len), .ir_high_len(ir_high_len),
    .ir_low_len(ir_low_len), .ir_rises(ir_rises));

  initial begin
    clock = 1'b0;
    forever #(CLOCK_PERIOD_NS / 2) clock = ~clock;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Write strobe stays up; the caller drops it with cyc before any gap
  task automatic wr(input irt_sel_t sel, input logic [REG_W-1:0] data);
    wr_en   <= 1'b1;
    wr_sel  <= sel;
    wr_data <= data;
    @(posedge clock);
  endtask

  task automatic cyc(input int n);
    wr_en <= 1'b0;
    repeat (n) @(posedge clock);
  endtask

  task automatic rd(input irt_sel_t sel, input int exp);
    rd_sel <= sel;
    repeat (2) @(posedge clock);
    check("read data", rd_data, exp[REG_W-1:0]);
  endtask

  task automatic wait_end(input int bound);
    int t;
    t = 0;
    while (timer_end !== 1'b1 && t < bound) begin
      @(posedge clock);
      t++;
      if (halt_release === 1'b1 && timer_end !== 1'b1) rel_early++;
    end
    check("end in time", t < bound, 1);
  endtask

  task automatic pins(input logic e, input logic ind, input logic ir);
    check("timer end", timer_end, e);
    check("indicator", indicator_pin, ind);
    check("ir pin", ir_drive_pin, ir);
  endtask

  initial begin
    #(CLOCK_PERIOD_NS * 40000);
    n_fail++;
    stop_test();
  end

  initial begin
    seed = 74478;
    n_fail = 0;
    check_count = 0;
    rel_early = 0;
    reset = 1'b1;
    wr_en = 1'b0;
    wr_sel = SEL_TIMER_FULL;
    wr_data = 10'h000;
    rd_sel = SEL_TIMER_FULL;
    stop_mode = 1'b0;
    halt_wait = 1'b0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    cyc(2);
    pins(1'b1, 1'b1, 1'b0);
    check("release idle", halt_release, 1'b0);
    rd(SEL_TIMER_FULL, 0);
    rd(SEL_LOW_FULL, 1);
    rd(SEL_HIGH_FULL, 1);
    mdl = '{1, 1};
    $display("test reset done");

    // Both modulo registers through every write and read form
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      if (i % 3 == 0) d = (d & 32'h200) | (1 + ((d >> 10) & 32'hFF));
      if (i % 3 == 1) d = d | 1;
      wr(irt_sel_t'(4'(3 + i)), d[REG_W-1:0]);
      cyc(1);
      if (i % 3 == 0) mdl[i/3] = d & 32'h3FF;
      if (i % 3 == 1) mdl[i/3] = (mdl[i/3] & 32'h3E0) | (d & 32'h1F);
      if (i % 3 == 2) mdl[i/3] = (mdl[i/3] & 32'h1F) | ((d & 32'h1F) << 5);
      mdl[0] = mdl[0] & 32'h1FF;
      rd(irt_sel_t'(4'(3 + 3 * (i / 3))), mdl[i/3]);
      rd(irt_sel_t'(4'(4 + 3 * (i / 3))), mdl[i/3] & 32'h1F);
      rd(irt_sel_t'(4'(5 + 3 * (i / 3))), mdl[i/3] >> 5);
    end
    $display("test registers done");

    wr(SEL_HIGH_FULL, 10'h201);
    wr(SEL_TIMER_FULL, 10'h200);
    cyc(3);
    pins(1'b1, 1'b1, 1'b0);
    wr(SEL_TIMER_FULL, 10'h003);
    cyc(2);
    pins(1'b0, 1'b1, 1'b0);
    rd(SEL_TIMER_B, 10'h000);
    wait_end(400);
    $display("test zero and disabled loads done");

    // Steady output: lamp lit and emitter high for the whole interval
    for (int i = 0; i < 2; i++) begin
      n1 = (i == 0) ? 1 : 2 + (($random(seed) & 32'h7FFF) % 3);
      wr(SEL_TIMER_FULL, 10'h200 | 10'(n1));
      cyc(2);
      pins(1'b0, 1'b0, 1'b1);
      wait_end(400);
      cyc(3);
      pins(1'b1, 1'b1, 1'b0);
      check("lit length", ind_low_len, (n1 + 1) * 64 - 4);
      check("ir length", ir_high_len, (n1 + 1) * 64 - 4);
    end
    $display("test steady output done");

    // Reload on the final decrement while the core waits in halt
    n1 = 1 + (($random(seed) & 32'h7FFF) % 3);
    n2 = 1 + (($random(seed) & 32'h7FFF) % 3);
    halt_wait <= 1'b1;
    wr(SEL_TIMER_FULL, 10'h200 | 10'(n1));
    cyc(64 * n1 + 59);
    wr(SEL_TIMER_FULL, 10'h200 | 10'(n2));
    cyc(2);
    wait_end(400);
    j = 0;
    while (halt_release !== 1'b1 && j < 4) begin
      @(posedge clock);
      j++;
    end
    halt_wait <= 1'b0;
    check("halt released", j < 4, 1);
    check("early release", rel_early, 0);
    cyc(3);
    check("chained length", ind_low_len, (n1 + n2 + 2) * 64 - 4);
    $display("test chained load done");

    // Carrier with random odd moduli, so each phase is a whole number of clocks
    k_hi = ($random(seed) & 32'h7FFF) % 8;
    k_lo = ($random(seed) & 32'h7FFF) % 8;
    wr(SEL_HIGH_FULL, 10'(2 * k_hi + 1));
    wr(SEL_LOW_FULL, 10'(2 * k_lo + 1));
    wr(SEL_TIMER_FULL, 10'h202);
    cyc(0);
    j = 0;
    while (ir_drive_pin !== 1'b1 && j < 20) begin
      @(posedge clock);
      j++;
    end
    check("low first", j >= k_lo + 1 && j <= k_lo + 4, 1);
    wait_end(400);
    cyc(k_hi + 4);
    check("ir after end", ir_drive_pin, 1'b0);
    check("high phase", ir_high_len, k_hi + 1);
    check("low phase", ir_low_len, k_lo + 1);
    check("carrier ran", ir_rises > 10, 1);
    $display("test carrier done");

    // Software pulse: a zero load cuts the shortest run 64-4 clocks in, before its first decrement
    wr(SEL_TIMER_FULL, 10'h201);
    cyc(59);
    wr(SEL_TIMER_FULL, 10'h200);
    cyc(3);
    check("short pulse", ind_low_len, 64 - 4);
    $display("test short pulse done");

    // Stop standby clears the count and drops timer loads
    wr(SEL_HIGH_FULL, 10'h201);
    wr(SEL_TIMER_FULL, 10'h205);
    cyc(10);
    stop_mode <= 1'b1;
    cyc(3);
    pins(1'b1, 1'b1, 1'b0);
    wr(SEL_TIMER_FULL, 10'h203);
    cyc(3);
    pins(1'b1, 1'b1, 1'b0);
    rd(SEL_TIMER_FULL, 10'h200);
    stop_mode <= 1'b0;
    cyc(2);
    $display("test stop standby done");
    stop_test();
  end
endmodule
`default_nettype wire
